// ---- logic/cswr_supervisor.v ----
// cpu supervisor: watchdog, power-on delay and low-supply reset
`include "cswr_defines.vh"

// What this block does
// - two-bit select picks 1.75s, 750ms, 250ms
// - off setting never lets watchdog reset
// - expired enabled watchdog asserts reset output
// - watchdog reset held about 250 ms
// - power-on reset held about 250 ms
// - low supply asserts reset within 500 ns
// - reset output is active-low open drain
module cswr_supervisor #(
  parameter integer WDT_1750_TICKS = `CSWR_MS_TO_TICKS(`CSWR_WDT_1750_MS),
  parameter integer WDT_750_TICKS = `CSWR_MS_TO_TICKS(`CSWR_WDT_750_MS),
  parameter integer WDT_250_TICKS = `CSWR_MS_TO_TICKS(`CSWR_WDT_250_MS),
  parameter integer RST_HOLD_TICKS = `CSWR_MS_TO_TICKS(`CSWR_RST_HOLD_MS),
  parameter integer POR_TICKS = `CSWR_MS_TO_TICKS(`CSWR_POR_DELAY_MS),
  parameter integer CNT_W = 17
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire xtal_tick_i,
  input wire wdt_period_sel_hi_i,
  input wire wdt_period_sel_lo_i,
  input wire low_supply_sense_i,
  input wire wdt_restart_i,
  output reg reset_n_o,
  output reg reset_oe_o,
  output reg wdt_expired_o
);

  localparam [CNT_W-1:0] W1750 = WDT_1750_TICKS[CNT_W-1:0];
  localparam [CNT_W-1:0] W750 = WDT_750_TICKS[CNT_W-1:0];
  localparam [CNT_W-1:0] W250 = WDT_250_TICKS[CNT_W-1:0];
  localparam [CNT_W-1:0] HOLD = RST_HOLD_TICKS[CNT_W-1:0];
  localparam [CNT_W-1:0] PORT = POR_TICKS[CNT_W-1:0];

  localparam [2:0] ST_POR = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  // bank order of the pins that cross into the clock domain
  localparam integer NPIN = 5;
  localparam integer P_TICK = 0;
  localparam integer P_LVS = 1;
  localparam integer P_RS = 2;
  localparam integer P_SLO = 3;
  localparam integer P_SHI = 4;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_sync;
  wire tick_q;
  wire lvs_q;
  wire rs_q;
  wire [1:0] sel_q;
  wire primed;
  wire tick;
  wire restart;
  wire run_nxt;
  reg tick_d_r;
  reg rs_d_r;
  reg [1:0] fill_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // counters sized for the longest period at the crystal rate
  reg [CNT_W-1:0] wdt_cnt_r;
  reg [CNT_W-1:0] wdt_cnt_nxt;
  reg [CNT_W-1:0] hold_cnt_r;
  reg [CNT_W-1:0] hold_cnt_nxt;
  reg [CNT_W-1:0] period;

  assign pin_raw = {wdt_period_sel_hi_i, wdt_period_sel_lo_i, wdt_restart_i,
    low_supply_sense_i, xtal_tick_i};

  // pins from outside: two flops before any logic reads them
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      always @(posedge mclk_i) begin
        if (!rst_n_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else if (ce_i) begin
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
        end
      end
      assign pin_sync[gi] = s2_r;
    end
  endgenerate

  // select bits are static settings, so no word handshake is needed
  assign tick_q = pin_sync[P_TICK];
  assign lvs_q = pin_sync[P_LVS];
  assign rs_q = pin_sync[P_RS];
  assign sel_q = {pin_sync[P_SHI], pin_sync[P_SLO]};

  // edge detect only once bank and delay flop hold real pin levels,
  // else a pin already high at reset release reads as a false edge
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tick_d_r <= 1'b0;
      rs_d_r <= 1'b0;
      fill_r <= 2'h0;
    end else if (ce_i) begin
      tick_d_r <= tick_q;
      rs_d_r <= rs_q;
      if (fill_r != 2'h3) begin
        fill_r <= fill_r + 2'h1;
      end
    end
  end

  assign primed = (fill_r == 2'h3);
  assign tick = primed & tick_q & ~tick_d_r;
  assign restart = primed & rs_q & ~rs_d_r;

  // off select gives zero; run state never counts then
  always @* begin
    case (sel_q)
      `CSWR_SEL_1750MS: period = W1750;
      `CSWR_SEL_750MS: period = W750;
      `CSWR_SEL_250MS: period = W250;
      default: period = {CNT_W{1'b0}};
    endcase
  end

  always @* begin
    state_nxt = state_r;
    wdt_cnt_nxt = wdt_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ST_POR: begin
        // counted only while supply is valid; a dip restarts the delay
        if (lvs_q) begin
          hold_cnt_nxt = {CNT_W{1'b0}};
        end else if (tick) begin
          if (hold_cnt_r >= PORT - 1'b1) begin
            state_nxt = ST_RUN;
            wdt_cnt_nxt = {CNT_W{1'b0}};
          end else begin
            hold_cnt_nxt = hold_cnt_r + 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (lvs_q) begin
          state_nxt = ST_POR;
          hold_cnt_nxt = {CNT_W{1'b0}};
        end else if (restart || sel_q == `CSWR_SEL_OFF) begin
          // restart and the off setting both clear the count
          wdt_cnt_nxt = {CNT_W{1'b0}};
        end else if (tick) begin
          if (wdt_cnt_r >= period - 1'b1) begin
            state_nxt = ST_HOLD;
            hold_cnt_nxt = {CNT_W{1'b0}};
          end else begin
            wdt_cnt_nxt = wdt_cnt_r + 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // restarts are ignored while the hold runs
        if (lvs_q) begin
          state_nxt = ST_POR;
          hold_cnt_nxt = {CNT_W{1'b0}};
        end else if (tick) begin
          if (hold_cnt_r >= HOLD - 1'b1) begin
            state_nxt = ST_RUN;
            wdt_cnt_nxt = {CNT_W{1'b0}};
          end else begin
            hold_cnt_nxt = hold_cnt_r + 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_POR;
        hold_cnt_nxt = {CNT_W{1'b0}};
      end
    endcase
  end

  // run only when the next state is run and supply is good
  assign run_nxt = (state_nxt == ST_RUN) && !lvs_q;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_POR;
      wdt_cnt_r <= {CNT_W{1'b0}};
      hold_cnt_r <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      state_r <= state_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // outputs registered so the pin never glitches on decode;
  // the sync and register stages cost three cycles, far inside 500 ns
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reset_n_o <= 1'b0;
      reset_oe_o <= 1'b1;
      wdt_expired_o <= 1'b0;
    end else if (ce_i) begin
      // low supply bypasses state so response stays in a few cycles
      reset_n_o <= run_nxt;
      reset_oe_o <= !run_nxt;
      wdt_expired_o <= (state_nxt == ST_HOLD);
    end
  end

endmodule

// ---- logic/cswr_defines.vh ----
// constants for the cpu supervisor watchdog and reset block
`ifndef CSWR_DEFINES_VH
`define CSWR_DEFINES_VH

`define CSWR_XTAL_HZ 32768
`define CSWR_MCLK_HZ 100000000
`define CSWR_SEL_1750MS 2'h0
`define CSWR_SEL_750MS 2'h1
`define CSWR_SEL_250MS 2'h2
`define CSWR_SEL_OFF 2'h3
`define CSWR_WDT_1750_MS 1750
`define CSWR_WDT_750_MS 750
`define CSWR_WDT_250_MS 250
`define CSWR_RST_HOLD_MS 250
`define CSWR_POR_DELAY_MS 250
`define CSWR_LVS_RESP_NS 500
`define CSWR_MS_TO_TICKS(ms) (((ms) * `CSWR_XTAL_HZ) / 1000)
`define CSWR_LVS_RESP_CYC ((`CSWR_LVS_RESP_NS * (`CSWR_MCLK_HZ / 1000000)) / 1000)

`endif

// ---- verif/cswr_supervisor_properties.sv ----
// port assertions for the supervisor
module cswr_sup_props (
  input wire mclk_i,
  input wire rst_n_i,
  input wire wdt_period_sel_hi_i,
  input wire wdt_period_sel_lo_i,
  input wire low_supply_sense_i,
  input wire wdt_restart_i,
  input wire reset_n_o,
  input wire reset_oe_o,
  input wire wdt_expired_o
);
  wire off = wdt_period_sel_hi_i & wdt_period_sel_lo_i;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_oe_tracks: assert property (reset_oe_o == !reset_n_o) else $error("oe");
  a_lvs_resp: assert property ($rose(low_supply_sense_i) |-> ##[1:50] !reset_n_o)
    else $error("lvs");
  a_exp_low: assert property (wdt_expired_o |-> !reset_n_o) else $error("exp");
  a_off_quiet: assert property (off && $past(off, 4) |-> !$rose(wdt_expired_o))
    else $error("off");
  a_por_ok: assert property ($rose(reset_n_o) |-> !$past(low_supply_sense_i, 4))
    else $error("por");
  a_hold_min: assert property ($rose(wdt_expired_o) |-> wdt_expired_o[*8])
    else $error("hold");
  a_hold_end: assert property ($fell(wdt_expired_o) && !low_supply_sense_i |-> ##[0:2] reset_n_o)
    else $error("end");
  a_kick_keeps: assert property ($rose(wdt_restart_i) && !wdt_expired_o ##4 reset_n_o
    |-> !wdt_expired_o[*8]) else $error("kick");
endmodule
bind cswr_supervisor cswr_sup_props i_cswr_sup_props (.*);

// ---- verif/cswr_host_model.sv ----
// host that kicks the watchdog with bus starts
module cswr_host_model (
  input wire logic mclk_i,
  input wire logic reset_pin_i,
  input wire logic svc_i,
  output logic restart_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int t = 0;
  initial restart_o = 1'b0;
  always @(posedge mclk_i) begin
    t <= reset_pin_i ? t + 1 : 0;
    // short settle after release, well inside the shortest period
    restart_o <= svc_i && t > 8 && t % 20 < 2;
  end
endmodule

// ---- verif/cswr_supervisor_tb_top.sv ----
// self-checking bench for the supervisor
module cswr_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic c = 0, rst_n = 0, tk = 0, hi = 0, lo = 0, low_supply_sense = 0, svc = 0, ce = 1, rs, rn, oe, ex, p;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic [31:0] lf = 32'h064D0462;
  wire pin = oe ? 1'b0 : 1'b1;
  cswr_supervisor #(.WDT_1750_TICKS(8), .WDT_750_TICKS(6), .WDT_250_TICKS(4),
    .RST_HOLD_TICKS(5), .POR_TICKS(5)) i_cswr_supervisor (.mclk_i(c), .rst_n_i(rst_n),
    .ce_i(ce), .xtal_tick_i(tk), .wdt_period_sel_hi_i(hi), .wdt_period_sel_lo_i(lo),
    .low_supply_sense_i(low_supply_sense), .wdt_restart_i(rs), .reset_n_o(rn), .reset_oe_o(oe),
    .wdt_expired_o(ex));
  cswr_host_model i_cswr_host_model (.mclk_i(c), .reset_pin_i(pin), .svc_i(svc), .restart_o(rs));
  initial forever #5 c = ~c;
  always @(posedge c) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) tk <= ~tk;
    if (cyc == 6000) begin
      fail_count++;
      conclude();
    end
  end
  function int per(input logic [1:0] s);
    return s == 2'h0 ? 8 : s == 2'h1 ? 6 : 4;
  endfunction
  task chk(input string nm, input int e, input int g);
    n_compared++;
    if (e != g) begin
      fail_count++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end else $display("ok %s", nm);
  endtask
  // counts tick rises while s holds v; idle ticks before that are skipped
  task automatic cnt(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v) @(posedge c);
    p = tk;
    while (s === v) begin
      @(posedge c);
      #1;
      k += int'(tk & ~p);
      p = tk;
    end
  endtask
  task low(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge c);
      #1;
      k += int'(rn !== 1'b1);
    end
  endtask
  task conclude();
    $display("compared %0d, bad %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    int k;
    logic [1:0] s;
    repeat (16) @(posedge c);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      s = (i < 3) ? 2'(i) : 2'(lf % 3);
      {hi, lo} <= s;
      cnt(rn, 1'b0, k);
      chk("hold", 5, k);
      cnt(rn, 1'b1, k);
      chk("period", per(s), k);
    end
    {hi, lo} <= 2'h2;
    svc <= 1'b1;
    cnt(rn, 1'b0, k);
    low(200 + lf[7:0], k);
    chk("kicked", 0, k);
    {hi, lo} <= 2'h3;
    svc <= 1'b0;
    low(300 + lf[15:8], k);
    chk("off", 0, k);
    ce <= 1'b0;
    {hi, lo} <= 2'h2;
    low(100, k);
    chk("frozen", 0, k);
    {hi, lo} <= 2'h3;
    @(posedge c);
    ce <= 1'b1;
    low_supply_sense <= 1'b1;
    k = 0;
    while (rn === 1'b1 && k < 60) begin
      @(posedge c);
      k++;
    end
    chk("lvs", 1, int'(k <= 50));
    repeat (30) @(posedge c);
    @(negedge tk);
    low_supply_sense <= 1'b0;
    cnt(rn, 1'b0, k);
    chk("por", 5, k);
    conclude();
  end
endmodule
